// *** design/brtc_defines.svh ***
// Register offsets, field positions, reset values and bus constants
`ifndef BRTC_DEFINES_SVH
`define BRTC_DEFINES_SVH
`define BRTC_ADDR_W 6
`define BRTC_NUM_REGS 64
`define BRTC_OFF_SEC 6'h00
`define BRTC_OFF_MIN 6'h01
`define BRTC_OFF_HOUR 6'h02
`define BRTC_OFF_WDAY 6'h03
`define BRTC_OFF_DATE 6'h04
`define BRTC_OFF_MON 6'h05
`define BRTC_OFF_YEAR 6'h06
`define BRTC_OFF_CTRL 6'h07
`define BRTC_OFF_RAM 6'h08
`define BRTC_MASK_SEC 8'hff
`define BRTC_MASK_MIN 8'h7f
`define BRTC_MASK_HOUR 8'h7f
`define BRTC_MASK_WDAY 8'h07
`define BRTC_MASK_DATE 8'h3f
`define BRTC_MASK_MON 8'h1f
`define BRTC_MASK_YEAR 8'hff
`define BRTC_MASK_CTRL 8'h93
`define BRTC_MASK_RAM 8'hff
`define BRTC_SEC_HALT_BIT 7
`define BRTC_HOUR_12H_BIT 6
`define BRTC_HOUR_PM_BIT 5
`define BRTC_CTRL_IDLE_BIT 7
`define BRTC_CTRL_SQWON_BIT 4
`define BRTC_CTRL_RATE_HI 1
`define BRTC_CTRL_RATE_LO 0
`define BRTC_RST_CTRL 8'h03
`define BRTC_RST_TIME 8'h00
`define BRTC_RST_DAYS 8'h01
`define BRTC_RATE_1HZ 2'h0
`define BRTC_RATE_4K 2'h1
`define BRTC_RATE_8K 2'h2
`define BRTC_RATE_32K 2'h3
`define BRTC_DIV_W 15
`define BRTC_DIV_LAST 15'h7fff
`define BRTC_DIV_1HZ_BIT 14
`define BRTC_DIV_4K_BIT 2
`define BRTC_DIV_8K_BIT 1
`define BRTC_SLAVE_ADDR 7'h68
`define BRTC_ACK_SLOT 4'h8
`define BRTC_AFTER_ACK 4'h9
`endif

// *** design/brtc_pkg.sv ***
// Types shared by the calendar clock design
package brtc_pkg;
  typedef enum logic [2:0] {
    BRTC_IDLE = 3'b000,
    BRTC_DEV = 3'b001,
    BRTC_PTR = 3'b010,
    BRTC_WDATA = 3'b011,
    BRTC_RDATA = 3'b100
  } brtc_i2c_state_t;
  typedef logic [7:0] brtc_byte_t;
endpackage

// *** design/brtc_top.sv ***
// BCD calendar clock with I2C slave, square-wave pin and user storage
`timescale 1ns/1ns
`default_nettype none
`include "brtc_defines.svh"

module brtc_top
  import brtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic crystal_in,
  output logic crystal_out,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic square_wave_pin_out,
  output logic square_wave_pin_oe_n
);

  // Pin synchronisers; stage 1 is read only by stage 2
  logic xtal_s1_ff, xtal_s2_ff, xtal_s3_ff;
  logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
  logic sda_s1_ff, sda_s2_ff, sda_s3_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      {xtal_s1_ff, xtal_s2_ff, xtal_s3_ff} <= 3'h0;
      {scl_s1_ff, scl_s2_ff, scl_s3_ff} <= 3'h7;
      {sda_s1_ff, sda_s2_ff, sda_s3_ff} <= 3'h7;
    end else begin
      xtal_s1_ff <= crystal_in;
      xtal_s2_ff <= xtal_s1_ff;
      xtal_s3_ff <= xtal_s2_ff;
      scl_s1_ff <= scl_in;
      scl_s2_ff <= scl_s1_ff;
      scl_s3_ff <= scl_s2_ff;
      sda_s1_ff <= sda_in;
      sda_s2_ff <= sda_s1_ff;
      sda_s3_ff <= sda_s2_ff;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s2_ff & ~scl_s3_ff;
  assign scl_fall = ~scl_s2_ff & scl_s3_ff;
  assign bus_start = scl_s2_ff & scl_s3_ff & ~sda_s2_ff & sda_s3_ff;
  assign bus_stop = scl_s2_ff & scl_s3_ff & sda_s2_ff & ~sda_s3_ff;

  brtc_byte_t regs_ff [`BRTC_NUM_REGS];
  brtc_byte_t nxt_regs [`BRTC_NUM_REGS];
  brtc_i2c_state_t state_ff, nxt_state;

  // Oscillator, divider and square wave
  logic [`BRTC_DIV_W-1:0] div_ff, nxt_div;
  logic tick_pend_ff, nxt_tick_pend;
  logic sqw_oe_n_ff, nxt_sqw_oe_n;
  logic xout_ff, nxt_xout;
  logic halt, ref_rise, div_wrap, tick_apply, wave_lvl;
  brtc_byte_t ctrl;

  assign ctrl = regs_ff[`BRTC_OFF_CTRL];
  assign halt = regs_ff[`BRTC_OFF_SEC][`BRTC_SEC_HALT_BIT];
  assign ref_rise = xtal_s2_ff & ~xtal_s3_ff & ~halt;
  // Wrap of the divider is the falling edge of its 1 Hz stage
  assign div_wrap = ref_rise && (div_ff == `BRTC_DIV_LAST);
  // Holding the tick off while the bus is busy keeps a burst read coherent
  assign tick_apply = tick_pend_ff && (state_ff == BRTC_IDLE);

  always_comb begin
    nxt_div = ref_rise ? div_ff + 15'h1 : div_ff;
    nxt_tick_pend = div_wrap | (tick_pend_ff & ~tick_apply);
    unique case (ctrl[`BRTC_CTRL_RATE_HI:`BRTC_CTRL_RATE_LO])
      `BRTC_RATE_1HZ: wave_lvl = div_ff[`BRTC_DIV_1HZ_BIT];
      `BRTC_RATE_4K: wave_lvl = div_ff[`BRTC_DIV_4K_BIT];
      `BRTC_RATE_8K: wave_lvl = div_ff[`BRTC_DIV_8K_BIT];
      `BRTC_RATE_32K: wave_lvl = xtal_s3_ff & ~halt;
    endcase
    // Open drain: only the enable moves, the pin level is always low
    if (ctrl[`BRTC_CTRL_SQWON_BIT]) begin
      nxt_sqw_oe_n = wave_lvl;
    end else begin
      nxt_sqw_oe_n = ctrl[`BRTC_CTRL_IDLE_BIT];
    end
    nxt_xout = ~xtal_s3_ff & ~halt;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_ff <= 15'h0;
      tick_pend_ff <= 1'b0;
      sqw_oe_n_ff <= 1'b1;
      xout_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick_pend_ff <= nxt_tick_pend;
      sqw_oe_n_ff <= nxt_sqw_oe_n;
      xout_ff <= nxt_xout;
    end
  end

  assign square_wave_pin_out = 1'b0;
  assign square_wave_pin_oe_n = sqw_oe_n_ff;
  assign crystal_out = xout_ff;

  // Calendar helpers
  function automatic brtc_byte_t bcd_inc(input brtc_byte_t v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  function automatic brtc_byte_t wr_mask(input logic [5:0] a);
    unique case (a)
      `BRTC_OFF_SEC: wr_mask = `BRTC_MASK_SEC;
      `BRTC_OFF_MIN: wr_mask = `BRTC_MASK_MIN;
      `BRTC_OFF_HOUR: wr_mask = `BRTC_MASK_HOUR;
      `BRTC_OFF_WDAY: wr_mask = `BRTC_MASK_WDAY;
      `BRTC_OFF_DATE: wr_mask = `BRTC_MASK_DATE;
      `BRTC_OFF_MON: wr_mask = `BRTC_MASK_MON;
      `BRTC_OFF_YEAR: wr_mask = `BRTC_MASK_YEAR;
      `BRTC_OFF_CTRL: wr_mask = `BRTC_MASK_CTRL;
      default: wr_mask = `BRTC_MASK_RAM;
    endcase
  endfunction

  // I2C slave
  logic [3:0] cnt_ff, nxt_cnt;
  logic [5:0] ptr_ff, nxt_ptr;
  brtc_byte_t shift_ff, nxt_shift, tx_ff, nxt_tx;
  logic sda_oe_n_ff, nxt_sda_oe_n, mack_ff, nxt_mack;
  logic carry, leap, wr_en;
  brtc_byte_t hr, mx_date, ld, sec_inc, hr12_inc;

  always_comb begin
    nxt_regs = regs_ff;
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_ptr = ptr_ff;
    nxt_shift = shift_ff;
    nxt_tx = tx_ff;
    nxt_sda_oe_n = sda_oe_n_ff;
    nxt_mack = mack_ff;
    wr_en = 1'b0;
    carry = 1'b0;
    hr = regs_ff[`BRTC_OFF_HOUR];
    ld = regs_ff[ptr_ff];
    sec_inc = bcd_inc({1'b0, regs_ff[`BRTC_OFF_SEC][6:0]});
    hr12_inc = bcd_inc({3'h0, regs_ff[`BRTC_OFF_HOUR][4:0]});
    leap = regs_ff[`BRTC_OFF_YEAR][4] ?
      (regs_ff[`BRTC_OFF_YEAR][3:0] inside {4'h2, 4'h6}) :
      (regs_ff[`BRTC_OFF_YEAR][3:0] inside {4'h0, 4'h4, 4'h8});
    unique case (regs_ff[`BRTC_OFF_MON])
      8'h02: mx_date = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: mx_date = 8'h30;
      default: mx_date = 8'h31;
    endcase
    if (bus_start) begin
      nxt_state = BRTC_DEV;
      nxt_cnt = 4'h0;
      nxt_sda_oe_n = 1'b1;
    end else if (bus_stop) begin
      nxt_state = BRTC_IDLE;
      nxt_sda_oe_n = 1'b1;
    end else if (state_ff != BRTC_IDLE && scl_rise) begin
      if (cnt_ff == `BRTC_ACK_SLOT) begin
        nxt_mack = ~sda_s2_ff;
      end else begin
        nxt_shift = {shift_ff[6:0], sda_s2_ff};
      end
      nxt_cnt = cnt_ff + 4'h1;
    end else if (state_ff != BRTC_IDLE && scl_fall) begin
      if (cnt_ff == `BRTC_ACK_SLOT) begin
        nxt_sda_oe_n = 1'b0;
        unique case (state_ff)
          BRTC_DEV: begin
            if (shift_ff[7:1] != `BRTC_SLAVE_ADDR) begin
              nxt_state = BRTC_IDLE;
              nxt_sda_oe_n = 1'b1;
            end else begin
              nxt_state = shift_ff[0] ? BRTC_RDATA : BRTC_PTR;
            end
          end
          BRTC_PTR: begin
            nxt_ptr = shift_ff[5:0];
            nxt_state = BRTC_WDATA;
          end
          BRTC_WDATA: begin
            wr_en = 1'b1;
            nxt_regs[ptr_ff] = shift_ff & wr_mask(ptr_ff);
            nxt_ptr = ptr_ff + 6'h1;
          end
          BRTC_RDATA: begin
            nxt_sda_oe_n = 1'b1;
            nxt_ptr = ptr_ff + 6'h1;
          end
          default: nxt_state = BRTC_IDLE;
        endcase
      end else if (cnt_ff == `BRTC_AFTER_ACK) begin
        nxt_cnt = 4'h0;
        nxt_sda_oe_n = 1'b1;
        // Our own address ack reads back as low, so a read starts here too
        if (state_ff == BRTC_RDATA) begin
          if (mack_ff) begin
            nxt_sda_oe_n = ld[7];
            nxt_tx = {ld[6:0], 1'b1};
          end else begin
            nxt_state = BRTC_IDLE;
          end
        end
      end else if (state_ff == BRTC_RDATA && cnt_ff != 4'h0) begin
        nxt_sda_oe_n = tx_ff[7];
        nxt_tx = {tx_ff[6:0], 1'b1};
      end
    end
    // Bus writes and the deferred tick never share a cycle
    if (tick_apply) begin
      nxt_regs[`BRTC_OFF_SEC][6:0] = (regs_ff[`BRTC_OFF_SEC][6:0] == 7'h59) ?
        7'h00 : sec_inc[6:0];
      if (regs_ff[`BRTC_OFF_SEC][6:0] == 7'h59) begin
        nxt_regs[`BRTC_OFF_MIN] = (regs_ff[`BRTC_OFF_MIN] == 8'h59) ?
          8'h00 : bcd_inc(regs_ff[`BRTC_OFF_MIN]);
        if (regs_ff[`BRTC_OFF_MIN] == 8'h59) begin
          if (hr[`BRTC_HOUR_12H_BIT]) begin
            if (hr[4:0] == 5'h11) begin
              carry = hr[`BRTC_HOUR_PM_BIT];
              hr = {2'h1, ~hr[`BRTC_HOUR_PM_BIT], 5'h12};
            end else if (hr[4:0] == 5'h12) begin
              hr = {hr[7:5], 5'h01};
            end else begin
              hr = {hr[7:5], hr12_inc[4:0]};
            end
          end else if (hr[5:0] == 6'h23) begin
            carry = 1'b1;
            hr = 8'h00;
          end else begin
            hr = bcd_inc(hr);
          end
          nxt_regs[`BRTC_OFF_HOUR] = hr;
        end
      end
      if (carry) begin
        nxt_regs[`BRTC_OFF_WDAY] = (regs_ff[`BRTC_OFF_WDAY] == 8'h07) ?
          8'h01 : bcd_inc(regs_ff[`BRTC_OFF_WDAY]);
        if (regs_ff[`BRTC_OFF_DATE] == mx_date) begin
          nxt_regs[`BRTC_OFF_DATE] = 8'h01;
          if (regs_ff[`BRTC_OFF_MON] == 8'h12) begin
            nxt_regs[`BRTC_OFF_MON] = 8'h01;
            nxt_regs[`BRTC_OFF_YEAR] = bcd_inc(regs_ff[`BRTC_OFF_YEAR]);
          end else begin
            nxt_regs[`BRTC_OFF_MON] = bcd_inc(regs_ff[`BRTC_OFF_MON]);
          end
        end else begin
          nxt_regs[`BRTC_OFF_DATE] = bcd_inc(regs_ff[`BRTC_OFF_DATE]);
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `BRTC_NUM_REGS; i++) begin
        regs_ff[i] <= `BRTC_RST_TIME;
      end
      regs_ff[`BRTC_OFF_WDAY] <= `BRTC_RST_DAYS;
      regs_ff[`BRTC_OFF_DATE] <= `BRTC_RST_DAYS;
      regs_ff[`BRTC_OFF_MON] <= `BRTC_RST_DAYS;
      regs_ff[`BRTC_OFF_CTRL] <= `BRTC_RST_CTRL;
      state_ff <= BRTC_IDLE;
      cnt_ff <= 4'h0;
      ptr_ff <= 6'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'hff;
      sda_oe_n_ff <= 1'b1;
      mack_ff <= 1'b0;
    end else begin
      regs_ff <= nxt_regs;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ptr_ff <= nxt_ptr;
      shift_ff <= nxt_shift;
      tx_ff <= nxt_tx;
      sda_oe_n_ff <= nxt_sda_oe_n;
      mack_ff <= nxt_mack;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = sda_oe_n_ff;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_idle_level: assert property (
    !ctrl[`BRTC_CTRL_SQWON_BIT] ##1 !ctrl[`BRTC_CTRL_SQWON_BIT] |->
      sqw_oe_n_ff == $past(ctrl[`BRTC_CTRL_IDLE_BIT]))
    else $error("square-wave pin not at idle level");
  chk_rate_8k: assert property (
    ctrl[4] && ctrl[1:0] == 2'h2 |=> sqw_oe_n_ff == $past(div_ff[1]))
    else $error("8k rate does not follow divider");
  chk_halt_freeze: assert property (
    halt |=> div_ff == $past(div_ff))
    else $error("divider ran while halted");
  chk_tick_pend: assert property (
    div_wrap |=> tick_pend_ff)
    else $error("1 Hz falling edge lost");
  chk_tick_defer: assert property (
    state_ff != BRTC_IDLE |=> regs_ff[0][6:0] == $past(regs_ff[0][6:0])
      || $past(wr_en))
    else $error("seconds moved during a transfer");
  chk_sec_wrap: assert property (
    tick_apply && regs_ff[0][6:0] == 7'h59 |=>
      regs_ff[0][6:0] == 7'h00 && regs_ff[1] != $past(regs_ff[1]))
    else $error("seconds wrap did not carry");
  chk_min_wrap: assert property (
    tick_apply && regs_ff[0][6:0] == 7'h59 && regs_ff[1] == 8'h59 |=>
      regs_ff[1] == 8'h00 && regs_ff[2] != $past(regs_ff[2]))
    else $error("minutes wrap did not carry");
  chk_zero_bits: assert property (
    regs_ff[1][7] == 1'b0 && regs_ff[3][7:3] == 5'h0 &&
      regs_ff[4][7:6] == 2'h0 && regs_ff[5][7:5] == 3'h0 &&
      (regs_ff[7] & ~`BRTC_MASK_CTRL) == 8'h00)
    else $error("fixed-zero bit is set");
  chk_wr_ptr: assert property (
    wr_en |=> ptr_ff == $past(ptr_ff) + 6'h1)
    else $error("pointer did not advance");

  cov_tick: cover property (tick_apply);
  cov_write: cover property (wr_en);
  cov_read: cover property (state_ff == BRTC_RDATA ##1 state_ff == BRTC_IDLE);
  cov_wave: cover property (ctrl[4] && $fell(sqw_oe_n_ff));

endmodule

`default_nettype wire

// *** verification/brtc_i2c_host.sv ***
// I2C bus master model that drives the calendar clock's serial port
`timescale 1ns/1ns
`default_nettype none
module brtc_i2c_host
  import brtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sda_bus,
  output logic scl,
  output logic sda_rel
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Quarter period of 5 cycles: 160 ns SCL, far above the bus ceiling to
  // save run time; the slave only needs each level held for 4 cycles
  task automatic q(input int n);
    repeat (n * 5) @(negedge ref_clk);
  endtask
  // SDA moves a quarter period after SCL fell, or for start and stop two quarters after SCL rose; never with it
  task automatic start();
    q(1);
    sda_rel = 1'b1;
    q(1);
    scl = 1'b1;
    q(2);
    sda_rel = 1'b0;
    q(2);
    scl = 1'b0;
  endtask
  task automatic stop();
    q(1);
    sda_rel = 1'b0;
    q(1);
    scl = 1'b1;
    q(2);
    sda_rel = 1'b1;
    q(2);
  endtask
  task automatic bitx(input logic b, output logic r);
    q(1);
    sda_rel = b;
    q(1);
    scl = 1'b1;
    q(2);
    r = sda_bus;
    scl = 1'b0;
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input brtc_byte_t d, input logic ai,
                      output brtc_byte_t r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r[i]);
    end
    bitx(ai, ack);
  endtask
endmodule
`default_nettype wire

// *** verification/brtc_top_test.sv ***
// Self-checking bench for the BCD calendar clock
`timescale 1ns/1ns
`default_nettype none
module brtc_top_test
  import brtc_pkg::*;
;
  logic ref_clk, sys_rst, crystal_in, crystal_out;
  logic sda_out, sda_oe_n, sq_out, sq_oe_n, scl, sda_rel;
  int miscompares, checks_done, rises;
  int cycles = 0;
  // Open-drain wire: low if either party pulls it
  wire sda_bus = sda_rel & (sda_oe_n | sda_out);

  brtc_top brtc_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .crystal_in(crystal_in), .crystal_out(crystal_out), .scl_in(scl),
    .sda_in(sda_bus), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .square_wave_pin_out(sq_out), .square_wave_pin_oe_n(sq_oe_n));
  brtc_i2c_host brtc_i2c_host_i (.ref_clk(ref_clk), .sda_bus(sda_bus),
    .scl(scl), .sda_rel(sda_rel));

  task automatic check(input brtc_byte_t seen, input brtc_byte_t exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    rises = 0;
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] p, input int n, input brtc_byte_t b[8]);
    brtc_byte_t r;
    logic a;
    brtc_i2c_host_i.start();
    brtc_i2c_host_i.xfer(8'hd0, 1'b1, r, a);
    check({7'h00, a}, 8'h00);
    brtc_i2c_host_i.xfer(p, 1'b1, r, a);
    for (int i = 0; i < n; i++) begin
      brtc_i2c_host_i.xfer(b[i], 1'b1, r, a);
      check({7'h00, a}, 8'h00);
    end
    brtc_i2c_host_i.stop();
  endtask
  task automatic rd(input logic [7:0] p, input int n, input brtc_byte_t e[8]);
    brtc_byte_t r;
    logic a;
    brtc_i2c_host_i.start();
    brtc_i2c_host_i.xfer(8'hd0, 1'b1, r, a);
    brtc_i2c_host_i.xfer(p, 1'b1, r, a);
    brtc_i2c_host_i.start();
    brtc_i2c_host_i.xfer(8'hd1, 1'b1, r, a);
    check({7'h00, a}, 8'h00);
    for (int i = 0; i < n; i++) begin
      brtc_i2c_host_i.xfer(8'hff, i == n - 1, r, a);
      check(r, e[i]);
    end
    brtc_i2c_host_i.stop();
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      crystal_in = 1'b1;
      @(negedge ref_clk);
      crystal_in = 1'b0;
      @(negedge ref_clk);
      rises++;
    end
  endtask
  task automatic t_reset();
    rd(8'h00, 8, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h03});
    $display("test reset values done");
  endtask
  task automatic t_store();
    wr(8'h48, 2, '{0: 8'ha5, 1: 8'h5a, default: 8'h00});
    rd(8'h08, 2, '{0: 8'ha5, 1: 8'h5a, default: 8'h00});
    wr(8'h3f, 2, '{0: 8'hc3, 1: 8'h22, default: 8'h00});
    rd(8'h3f, 2, '{0: 8'hc3, 1: 8'h22, default: 8'h00});
    $display("test storage and pointer done");
  endtask
  task automatic t_fixed();
    brtc_byte_t r;
    logic a;
    wr(8'h01, 7, '{default: 8'hff});
    rd(8'h01, 7, '{8'h7f, 8'h7f, 8'h07, 8'h3f, 8'h1f, 8'hff, 8'h93, 8'h00});
    // A neighbouring address must be ignored
    brtc_i2c_host_i.start();
    brtc_i2c_host_i.xfer(8'hd2, 1'b1, r, a);
    check({7'h00, a}, 8'h01);
    brtc_i2c_host_i.stop();
    $display("test fixed bits and address done");
  endtask
  task automatic t_wave();
    wr(8'h07, 1, '{default: 8'h00});
    repeat (8) @(negedge ref_clk);
    check({7'h00, sq_oe_n}, 8'h00);
    check({7'h00, sq_out}, 8'h00);
    wr(8'h07, 1, '{default: 8'h80});
    repeat (8) @(negedge ref_clk);
    check({7'h00, sq_oe_n}, 8'h01);
    wr(8'h07, 1, '{default: 8'h13});
    crystal_in = 1'b1;
    repeat (8) @(negedge ref_clk);
    check({7'h00, sq_oe_n}, 8'h01);
    crystal_in = 1'b0;
    rises++;
    repeat (8) @(negedge ref_clk);
    check({7'h00, sq_oe_n}, 8'h00);
    // Divider taps: rate 01 follows count bit 2, rate 10 count bit 1
    for (int k = 1; k < 3; k++) begin
      wr(8'h07, 1, '{default: 8'h10 | k[7:0]});
      pulse(3);
      repeat (8) @(negedge ref_clk);
      check({7'h00, sq_oe_n}, {7'h00, rises[3 - k]});
    end
    $display("test square wave done");
  endtask
  task automatic t_tick();
    do_reset();
    wr(8'h00, 7, '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h04, 8'h00});
    wr(8'h07, 1, '{default: 8'h10});
    pulse(16400);
    check({7'h00, sq_oe_n}, 8'h01);
    pulse(16368);
    repeat (8) @(negedge ref_clk);
    check({7'h00, sq_oe_n}, 8'h00);
    rd(8'h00, 7, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h04, 8'h00});
    $display("test one second carry done");
  endtask
  task automatic t_halt();
    wr(8'h00, 1, '{default: 8'h80});
    wr(8'h07, 1, '{default: 8'h13});
    crystal_in = 1'b1;
    repeat (8) @(negedge ref_clk);
    check({7'h00, crystal_out}, 8'h00);
    check({7'h00, sq_oe_n}, 8'h00);
    rd(8'h00, 1, '{default: 8'h80});
    crystal_in = 1'b0;
    wr(8'h00, 1, '{default: 8'h00});
    repeat (8) @(negedge ref_clk);
    check({7'h00, crystal_out}, 8'h01);
    crystal_in = 1'b1;
    repeat (8) @(negedge ref_clk);
    check({7'h00, sq_oe_n}, 8'h01);
    check({7'h00, crystal_out}, 8'h00);
    crystal_in = 1'b0;
    $display("test oscillator halt done");
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // One second of reference rises at two cycles each dominates; near 85k
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 100000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    sys_rst = 1'b1;
    crystal_in = 1'b0;
    miscompares = 0;
    checks_done = 0;
    rises = 0;
    do_reset();
    t_reset();
    t_store();
    t_fixed();
    t_wave();
    t_tick();
    t_halt();
    conclude();
  end
endmodule
`default_nettype wire
